// file: common/msc_pkg.sv
// Constants, codes and the configuration word layout for the
// miscellaneous configuration word block.
// Assumes a single 20 MHz core clock and a word loaded by the chip.
//
// Summary of operation
// RQ1 - Interrupt pin select: clear routes processor interrupt to pin 3, set to pin 4.
// RQ2 - Display clock polarity: clear gives active-low pulse, set gives active-high.
// RQ3 - Gain cycle modification disable set suppresses modification; clear applies it.
// RQ4 - Comparator source: clear picks internal comparator, set picks external.
// RQ5 - Comparator switch: 00 off, 01 measuring, 10 loading, 11 always on.
// RQ6 - Memory clock speed field: code 00 fastest, code 11 slowest.
// RQ7 - Interrupt edge: clear responds to rising edge, set to falling edge.
// RQ8 - Exclusive interrupt enable pauses measurement until servicing completes.
// RQ9 - Pin 3 output codes: value, measurement-done, serial transmit, display clock.
// RQ10 - Pin 3 input codes: 0 plain input, 1 external interrupt source.
// RQ11 - Display clock select: off, or 100 ns, 200 ns, 800 ns pulses.
// RQ12 - Display clock runs at twice the 10 kHz internal clock.
// RQ13 - Software must route pin 3 or 4 to display clock to see it.
// RQ14 - Supply refresh at 20, 10, 5 Hz, or after every averaging end.
// RQ15 - Interference suppress bit selects the modified measurement sequencing.
// RQ16 - Display clock drive: clear push-pull, set open-drain on pin 3 or 4.
// RQ17 - One-time memory keep-powered bit keeps that memory permanently powered.
// RQ18 - Programming time: 6.4 ms both, 12.6 ms, 6.4 erase, 6.4 write.
// RQ19 - Redundancy: clear uses full 8k, set stores bits twice giving 4K.

package msc_pkg;

  // Clock and time base.
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned CLK_NS = 50;
  localparam int unsigned BASE_CLK_HZ = 10_000;
  localparam int unsigned LCD_CLK_HZ = 2 * BASE_CLK_HZ;
  localparam int unsigned LCD_PERIOD_CYC = CLK_HZ / LCD_CLK_HZ;

  // Display clock pulse widths, rounded up to whole cycles.
  localparam int unsigned LCD_PW1_NS = 100;
  localparam int unsigned LCD_PW2_NS = 200;
  localparam int unsigned LCD_PW3_NS = 800;
  localparam int unsigned LCD_PW1_CYC = (LCD_PW1_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned LCD_PW2_CYC = (LCD_PW2_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned LCD_PW3_CYC = (LCD_PW3_NS + CLK_NS - 1) / CLK_NS;

  // Supply refresh rates.
  localparam int unsigned REFR0_HZ = 20;
  localparam int unsigned REFR1_HZ = 10;
  localparam int unsigned REFR2_HZ = 5;
  localparam int unsigned REFR0_CYC = CLK_HZ / REFR0_HZ;
  localparam int unsigned REFR1_CYC = CLK_HZ / REFR1_HZ;
  localparam int unsigned REFR2_CYC = CLK_HZ / REFR2_HZ;

  // Nonvolatile programming times in microseconds.
  localparam int unsigned PROG_SHORT_US = 6400;
  localparam int unsigned PROG_LONG_US = 12600;
  localparam int unsigned PROG_SHORT_CYC = PROG_SHORT_US * (CLK_HZ / 1_000_000);
  localparam int unsigned PROG_LONG_CYC = PROG_LONG_US * (CLK_HZ / 1_000_000);

  // Memory clock half period at the fastest speed code.
  localparam int unsigned MEM_HALF_MIN_CYC = 2;

  // Field codes.
  localparam logic [1:0] CMP_OFF = 2'h0;
  localparam logic [1:0] CMP_MEAS = 2'h1;
  localparam logic [1:0] CMP_LOAD = 2'h2;
  localparam logic [1:0] CMP_ON = 2'h3;
  localparam logic [1:0] P3_PLAIN = 2'h0;
  localparam logic [1:0] P3_MEAS_IRQ = 2'h1;
  localparam logic [1:0] P3_UART = 2'h2;
  localparam logic [1:0] P3_LCD = 2'h3;
  localparam logic [1:0] LCD_OFF = 2'h0;
  localparam logic [1:0] LCD_PW1 = 2'h1;
  localparam logic [1:0] LCD_PW2 = 2'h2;
  localparam logic [1:0] REFR_AVG = 2'h3;
  localparam logic [1:0] PRG_BOTH = 2'h0;
  localparam logic [1:0] PRG_LONG = 2'h1;
  localparam logic [1:0] PRG_ERASE = 2'h2;
  localparam logic [1:0] PRG_WRITE = 2'h3;

  // Configuration word fields.
  typedef struct packed {
    logic irq_pin_sel;
    logic lcd_pol;
    logic gain_cycle_mod_disable;
    logic comp_ext;
    logic [1:0] comp_switch;
    logic [1:0] mem_clk_speed;
    logic irq_edge_fall;
    logic irq_excl_en;
    logic pin3_is_input;
    logic [1:0] pin3_function_select;
    logic [1:0] lcd_clk_sel;
    logic [1:0] refresh_sel;
    logic interference_suppress_enable;
    logic lcd_open_drain;
    logic otp_keep_on;
    logic [1:0] prog_time;
    logic otp_redundancy;
  } msc_cfg_t;

  // Gain modification off, memory clock code 1, interference suppress on.
  localparam msc_cfg_t CFG_RESET = msc_cfg_t'(23'h108020);

endpackage

// file: dv/msc_config_word_tb_top.sv
// Self-checking bench for the configuration word block.
// Assumes msc_pkg and the processor model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module msc_config_word_tb_top;
  import msc_pkg::*;
  logic clk, rst_n, load, p3, p4, p3v, mdone, txd, sdone, meas, ld;
  logic run, avg, pst, otp, lcdn;
  msc_cfg_t cfg, cfg_o, b;
  logic p3o, p3oe, lcd, lcdoe, irq, pause, cmp_on, cmp_ext, gmod, isup;
  logic mclk, refr, busy, er, wr, pdone, opwr, dbl, k4, ok;
  logic [7:0] dly;
  logic [1:0] q[$];
  int n_mismatch, checks, n;

  msc_config_word #(.REFR0_P(40), .REFR1_P(80), .REFR2_P(160),
    .PROG_SHORT_P(20), .PROG_LONG_P(40)) u_dut (
    .core_clk_in(clk), .reset_n_in(rst_n), .cfg_in(cfg), .cfg_load_in(load),
    .multipurpose_pin_3_in(p3), .general_pin_four_in(p4),
    .pin3_value_in(p3v), .meas_done_irq_in(mdone), .uart_txd_in(txd),
    .irq_service_done_in(sdone), .meas_active_in(meas),
    .load_active_in(ld), .mem_clk_run_in(run), .avg_end_in(avg),
    .prog_start_in(pst), .otp_access_in(otp), .cfg_out(cfg_o),
    .multipurpose_pin_3_out(p3o), .multipurpose_pin_3_oe_out(p3oe),
    .lcd_clk_out(lcd), .lcd_clk_oe_out(lcdoe), .cpu_irq_out(irq),
    .meas_pause_out(pause), .comp_on_out(cmp_on), .comp_ext_out(cmp_ext),
    .gain_cycle_mod_en_out(gmod), .interference_suppress_out(isup),
    .mem_clk_out(mclk), .refresh_out(refr), .prog_busy_out(busy),
    .prog_erase_out(er), .prog_write_out(wr), .prog_done_out(pdone),
    .otp_power_out(opwr), .otp_double_bits_out(dbl),
    .otp_size_4k_out(k4));
  msc_cpu_model u_cpu (.core_clk_in(clk), .reset_n_in(rst_n),
    .cpu_irq_in(irq), .delay_in(dly), .service_done_out(sdone));

  // Free-running 20 MHz clock and an inverted display clock copy.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always_comb lcdn = ~lcd;

  task automatic note(input bit good, input logic [31:0] g, e);
    checks++;
    if (!good) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    note(g === e, 32'(g), 32'(e));
  endtask
  task automatic chk_cfg(input msc_cfg_t g, input msc_cfg_t e);
    note(g === e, 32'(g), 32'(e));
  endtask
  task automatic chk_evt(input logic [1:0] g, input logic [1:0] e);
    note(g === e, 32'(g), 32'(e));
  endtask
  task automatic chk_cnt(input int g, input int e);
    note(g == e, g, e);
  endtask

  task automatic test_done();
    $display("n_mismatch=%0d checks=%0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // A wait that runs out counts as a mismatch and ends the run.
  task automatic wait_hi(ref logic s, input int lim);
    int k;
    k = 0;
    while (s !== 1'b1) begin
      @(negedge clk);
      k++;
      if (k > lim) begin
        n_mismatch++;
        test_done();
      end
    end
  endtask
  // Skips any pulse in progress so only a whole high phase is counted.
  task automatic hi_len(ref logic s, input int lim, output int len);
    int k;
    k = 0;
    while (s === 1'b1 && k < lim) begin
      @(negedge clk);
      k++;
    end
    wait_hi(s, lim);
    len = 0;
    while (s === 1'b1 && len < lim) begin
      @(negedge clk);
      len++;
    end
  endtask
  task automatic per_of(ref logic s, input int lim, output int len);
    wait_hi(s, lim);
    len = 0;
    while (s === 1'b1 && len < lim) begin
      @(negedge clk);
      len++;
    end
    while (s !== 1'b1 && len < lim) begin
      @(negedge clk);
      len++;
    end
  endtask
  task automatic load_cfg(input msc_cfg_t c);
    cfg = c;
    load = 1'b1;
    @(negedge clk);
    load = 1'b0;
  endtask

  // Each interrupt or programming-done pulse retires the oldest note.
  // Sampled mid-cycle so the registered pulses have settled.
  always @(negedge clk) begin
    if (rst_n === 1'b1 && (irq === 1'b1 || pdone === 1'b1)) begin
      if (q.size() == 0) begin
        note(1'b0, 32'({irq, pdone}), 32'h0);
      end else begin
        chk_evt({irq, pdone}, q.pop_front());
      end
    end
  end

  // Main sequence; all inputs change at the falling edge.
  initial begin
    void'($urandom(32'h20644F89));
    {load, p3, p4, p3v, mdone, txd, meas, ld, run, avg, pst, otp} = '0;
    cfg = '0;
    // Service delay must outlast the second pin check and end in time.
    dly = 8'h08 + 8'($urandom & 32'h0000001F);
    n_mismatch = 0;
    checks = 0;
    rst_n = 1'b0;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    chk_cfg(cfg_o, CFG_RESET);
    repeat (8) begin
      b = 23'($urandom);
      otp = 1'($urandom);
      load_cfg(b);
      chk_cfg(cfg_o, b);
      chk_bit(cmp_ext, b.comp_ext);
      chk_bit(gmod, ~b.gain_cycle_mod_disable);
      chk_bit(isup, b.interference_suppress_enable);
      chk_bit(opwr, b.otp_keep_on | otp);
      chk_bit(dbl, b.otp_redundancy);
      chk_bit(k4, b.otp_redundancy);
      @(negedge clk);
    end
    b = '0;
    for (int i = 0; i < 16; i++) begin
      b.comp_switch = i[3:2];
      b.pin3_function_select = i[1:0];
      b.lcd_pol = i[2];
      {meas, ld} = i[1:0];
      {p3v, mdone, txd} = 3'($urandom);
      load_cfg(b);
      ok = (i[3:2] == 3) | (i[3:2] == 1 & meas) | (i[3:2] == 2 & ld);
      chk_bit(cmp_on, ok);
      // Pin 3 drivers are registered, so they follow one cycle later.
      @(negedge clk);
      ok = (i[1:0] == 0) ? p3v : (i[1:0] == 1) ? mdone : txd;
      chk_bit(p3o, i[1:0] == 3 ? ~b.lcd_pol : ok);
      chk_bit(p3oe, 1'b1);
    end
    for (int c = 0; c < 3; c++) begin
      b.refresh_sel = 2'(c);
      load_cfg(b);
      per_of(refr, 400, n);
      chk_cnt(n, 40 << c);
    end
    b.refresh_sel = REFR_AVG;
    load_cfg(b);
    for (int k = 0; k < 5; k++) begin
      avg = (k == 0) | 1'($urandom);
      ok = avg;
      @(negedge clk);
      chk_bit(refr, ok);
    end
    avg = 1'b0;
    run = 1'b1;
    for (int c = 0; c < 4; c++) begin
      b.mem_clk_speed = 2'(c);
      load_cfg(b);
      hi_len(mclk, 100, n);
      chk_cnt(n, 2 << c);
    end
    run = 1'b0;
    repeat (40) @(negedge clk);
    chk_bit(mclk, 1'b0);
    b.lcd_pol = 1'b1;
    for (int c = 1; c < 4; c++) begin
      b.lcd_clk_sel = 2'(c);
      load_cfg(b);
      hi_len(lcd, 1100, n);
      chk_cnt(n, c == 3 ? 16 : 2 * c);
      per_of(lcd, 1100, n);
      chk_cnt(n, 1000);
      hi_len(p3o, 1100, n);
      chk_cnt(n, c == 3 ? 16 : 2 * c);
      chk_bit(lcdoe, 1'b1);
    end
    b.lcd_pol = 1'b0;
    load_cfg(b);
    hi_len(lcdn, 1100, n);
    chk_cnt(n, 16);
    b.lcd_open_drain = 1'b1;
    load_cfg(b);
    hi_len(lcdoe, 1100, n);
    chk_cnt(n, 16);
    chk_bit(lcd, 1'b0);
    b = '0;
    for (int c = 0; c < 4; c++) begin
      b.prog_time = 2'(c);
      load_cfg(b);
      q.push_back(2'b01);
      pst = 1'b1;
      @(negedge clk);
      pst = 1'b0;
      chk_bit(er, c != 3);
      chk_bit(wr, c == 3);
      n = 0;
      while (busy === 1'b1 && n < 100) begin
        pst = (n == 3);
        if (n == 15) chk_bit(wr, c == 0 || c == 3);
        @(negedge clk);
        n++;
      end
      chk_cnt(n, c == 1 ? 40 : 20);
    end
    for (int i = 0; i < 16; i++) begin
      b = '0;
      {b.irq_excl_en, b.irq_edge_fall, b.irq_pin_sel} = i[2:0];
      b.pin3_is_input = 1'b1;
      b.pin3_function_select = {1'b0, ~i[3]};
      load_cfg(b);
      @(negedge clk);
      chk_bit(p3oe, 1'b0);
      ok = i[2] && (i[0] || !i[3]);
      if (ok) q.push_back(2'b10);
      {p3, p4} = i[0] ? {1'($urandom), 1'b0} : {1'b0, 1'($urandom)};
      repeat (6) @(negedge clk);
      {p3, p4} = 2'b00;
      repeat (6) @(negedge clk);
      {p3, p4} = i[0] ? 2'b01 : 2'b10;
      repeat (6) @(negedge clk);
      chk_bit(pause, ok & ~i[1]);
      {p3, p4} = 2'b00;
      repeat (6) @(negedge clk);
      chk_bit(pause, ok);
      repeat (40) @(negedge clk);
      chk_bit(pause, 1'b0);
    end
    chk_cnt(q.size(), 0);
    test_done();
  end
endmodule
`default_nettype wire

// file: dv/msc_cpu_model.sv
// Processor model: services each interrupt pulse after a set delay.
// Assumes the block's clock and reset; delay_in is at least one.
`timescale 1ns/10ps
`default_nettype none
module msc_cpu_model (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic cpu_irq_in,
  input wire logic [7:0] delay_in,
  output logic service_done_out
);
  int cnt;
  // A long delay keeps the measurement paused, so the pause is visible.
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cnt <= 0;
      service_done_out <= 1'b0;
    end else begin
      service_done_out <= (cnt == 1);
      if (cpu_irq_in) begin
        cnt <= int'(delay_in) + 1;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule
`default_nettype wire

// file: src/msc_config_word.sv
// Miscellaneous configuration word and the logic its fields steer.
// Assumes cfg_in is loaded by the chip's configuration load strobe and
// that all inputs except the two pins come from core_clk_in logic.
`timescale 1ns/10ps
`default_nettype none
module msc_config_word
  import msc_pkg::*;
#(
  parameter int unsigned REFR0_P = REFR0_CYC,
  parameter int unsigned REFR1_P = REFR1_CYC,
  parameter int unsigned REFR2_P = REFR2_CYC,
  parameter int unsigned PROG_SHORT_P = PROG_SHORT_CYC,
  parameter int unsigned PROG_LONG_P = PROG_LONG_CYC
) (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire msc_cfg_t cfg_in,
  input wire logic cfg_load_in,
  input wire logic multipurpose_pin_3_in,
  input wire logic general_pin_four_in,
  input wire logic pin3_value_in,
  input wire logic meas_done_irq_in,
  input wire logic uart_txd_in,
  input wire logic irq_service_done_in,
  input wire logic meas_active_in,
  input wire logic load_active_in,
  input wire logic mem_clk_run_in,
  input wire logic avg_end_in,
  input wire logic prog_start_in,
  input wire logic otp_access_in,
  output msc_cfg_t cfg_out,
  output logic multipurpose_pin_3_out,
  output logic multipurpose_pin_3_oe_out,
  output logic lcd_clk_out,
  output logic lcd_clk_oe_out,
  output logic cpu_irq_out,
  output logic meas_pause_out,
  output logic comp_on_out,
  output logic comp_ext_out,
  output logic gain_cycle_mod_en_out,
  output logic interference_suppress_out,
  output logic mem_clk_out,
  output logic refresh_out,
  output logic prog_busy_out,
  output logic prog_erase_out,
  output logic prog_write_out,
  output logic prog_done_out,
  output logic otp_power_out,
  output logic otp_double_bits_out,
  output logic otp_size_4k_out
);
  typedef enum logic [2:0] {
    MSC_PRG_IDLE = 3'b001,
    MSC_PRG_RUN = 3'b010,
    MSC_PRG_DONE = 3'b100
  } msc_prg_state_t;

  msc_cfg_t cfg_r;
  logic p3_rise, p3_fall;
  logic p4_rise, p4_fall;
  logic lcd_tick, refr_tick, mem_tick;
  logic [4:0] lcd_cnt_r;
  logic [4:0] lcd_cnt_nxt;
  logic p3_out_r, p3_oe_r, lcd_out_r, lcd_oe_r;
  logic irq_r, pause_r, mem_clk_r, refresh_r;
  msc_prg_state_t prg_r, prg_nxt;
  logic [23:0] prg_cnt_r;
  logic [1:0] prg_code_r;

  // The word is captured only on the load strobe, so a half-written
  // source never disturbs the running outputs.
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cfg_r <= CFG_RESET;
    end else if (cfg_load_in) begin
      cfg_r <= cfg_in;
    end
  end
  assign cfg_out = cfg_r;

  // Both pins cross in from outside and are synchronised first.
  msc_sync_edge u_sync_p3 (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .pin_in(multipurpose_pin_3_in),
    .level_out(),
    .rise_out(p3_rise),
    .fall_out(p3_fall)
  );
  msc_sync_edge u_sync_p4 (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .pin_in(general_pin_four_in),
    .level_out(),
    .rise_out(p4_rise),
    .fall_out(p4_fall)
  );

  // RQ10 pin 3 interrupt input
  wire p3_irq_src_w = cfg_r.pin3_is_input &
                      (cfg_r.pin3_function_select == P3_MEAS_IRQ);
  // RQ1 interrupt pin routing
  wire src_rise_w = cfg_r.irq_pin_sel ? p4_rise : (p3_rise & p3_irq_src_w);
  wire src_fall_w = cfg_r.irq_pin_sel ? p4_fall : (p3_fall & p3_irq_src_w);
  // RQ7 interrupt edge choice
  wire irq_edge_w = cfg_r.irq_edge_fall ? src_fall_w : src_rise_w;
  wire irq_fire_w = irq_edge_w & cfg_r.irq_excl_en;

  // RQ8 measurement pause
  // A new edge during servicing keeps the pause; set wins over done.
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_r <= 1'b0;
      pause_r <= 1'b0;
    end else begin
      irq_r <= irq_fire_w;
      pause_r <= irq_fire_w | (pause_r & ~irq_service_done_in);
    end
  end
  assign cpu_irq_out = irq_r;
  assign meas_pause_out = pause_r;

  // RQ12 display clock rate
  msc_tick_div #(.W(10)) u_lcd_div (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .restart_in(cfg_r.lcd_clk_sel == LCD_OFF),
    .period_in(10'(LCD_PERIOD_CYC)),
    .tick_out(lcd_tick)
  );

  // RQ11 display pulse width
  wire [4:0] lcd_width_w =
    (cfg_r.lcd_clk_sel == LCD_PW1) ? 5'(LCD_PW1_CYC) :
    (cfg_r.lcd_clk_sel == LCD_PW2) ? 5'(LCD_PW2_CYC) : 5'(LCD_PW3_CYC);
  assign lcd_cnt_nxt = (cfg_r.lcd_clk_sel == LCD_OFF) ? 5'h00 :
                       lcd_tick ? lcd_width_w :
                       (lcd_cnt_r != 5'h00) ? lcd_cnt_r - 5'h01 : 5'h00;
  wire lcd_act_w = lcd_cnt_r != 5'h00;
  // RQ2 display clock polarity
  wire lcd_lvl_w = cfg_r.lcd_pol ? lcd_act_w : ~lcd_act_w;
  // RQ16 open-drain option
  // Open-drain only pulls low; the external pull-up makes the high level.
  wire lcd_pin_out_w = cfg_r.lcd_open_drain ? 1'b0 : lcd_lvl_w;
  wire lcd_pin_oe_w = cfg_r.lcd_open_drain ? ~lcd_lvl_w : 1'b1;

  // RQ9 pin 3 output select
  wire p3_mux_w =
    (cfg_r.pin3_function_select == P3_PLAIN) ? pin3_value_in :
    (cfg_r.pin3_function_select == P3_MEAS_IRQ) ? meas_done_irq_in :
    (cfg_r.pin3_function_select == P3_UART) ? uart_txd_in : lcd_pin_out_w;
  wire p3_lcd_w = cfg_r.pin3_function_select == P3_LCD;
  wire p3_oe_w = ~cfg_r.pin3_is_input & (p3_lcd_w ? lcd_pin_oe_w : 1'b1);

  // Pin and display clock drivers are registered to keep them glitch free.
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      lcd_cnt_r <= 5'h00;
      lcd_out_r <= 1'b0;
      lcd_oe_r <= 1'b0;
      p3_out_r <= 1'b0;
      p3_oe_r <= 1'b0;
    end else begin
      lcd_cnt_r <= lcd_cnt_nxt;
      lcd_out_r <= lcd_pin_out_w;
      lcd_oe_r <= lcd_pin_oe_w & (cfg_r.lcd_clk_sel != LCD_OFF);
      p3_out_r <= p3_mux_w;
      p3_oe_r <= p3_oe_w;
    end
  end
  assign multipurpose_pin_3_out = p3_out_r;
  assign multipurpose_pin_3_oe_out = p3_oe_r;
  // RQ13 pin 4 routing outside
  // The pin 4 multiplexer outside takes these when routed to the clock.
  assign lcd_clk_out = lcd_out_r;
  assign lcd_clk_oe_out = lcd_oe_r;

  // RQ4 comparator source
  assign comp_ext_out = cfg_r.comp_ext;
  // RQ5 comparator switching
  assign comp_on_out = (cfg_r.comp_switch == CMP_ON) |
                       ((cfg_r.comp_switch == CMP_MEAS) & meas_active_in) |
                       ((cfg_r.comp_switch == CMP_LOAD) & load_active_in);
  // RQ3 gain modification
  assign gain_cycle_mod_en_out = ~cfg_r.gain_cycle_mod_disable;
  // RQ15 interference suppression
  assign interference_suppress_out = cfg_r.interference_suppress_enable;
  // RQ17 memory keep powered
  assign otp_power_out = cfg_r.otp_keep_on | otp_access_in;
  // RQ19 redundancy mode
  assign otp_double_bits_out = cfg_r.otp_redundancy;
  assign otp_size_4k_out = cfg_r.otp_redundancy;

  // RQ6 memory clock speed
  // Each code step doubles the half period, so 00 is the fastest.
  wire [4:0] mem_half_w = 5'(MEM_HALF_MIN_CYC) << cfg_r.mem_clk_speed;
  msc_tick_div #(.W(5)) u_mem_div (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .restart_in(~mem_clk_run_in),
    .period_in(mem_half_w),
    .tick_out(mem_tick)
  );

  // RQ14 supply refresh period
  wire [23:0] refr_per_w =
    (cfg_r.refresh_sel == 2'h0) ? 24'(REFR0_P) :
    (cfg_r.refresh_sel == 2'h1) ? 24'(REFR1_P) : 24'(REFR2_P);
  wire refr_avg_w = cfg_r.refresh_sel == REFR_AVG;
  msc_tick_div #(.W(24)) u_refr_div (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .restart_in(refr_avg_w),
    .period_in(refr_per_w),
    .tick_out(refr_tick)
  );

  // The memory clock idles low whenever no transfer runs.
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mem_clk_r <= 1'b0;
      refresh_r <= 1'b0;
    end else begin
      mem_clk_r <= mem_clk_run_in & (mem_clk_r ^ mem_tick);
      refresh_r <= refr_avg_w ? avg_end_in : refr_tick;
    end
  end
  assign mem_clk_out = mem_clk_r;
  assign refresh_out = refresh_r;

  // RQ18 programming time
  // The code is latched at start so a reload mid-cycle cannot cut it short.
  wire [23:0] prg_len_w = (prg_code_r == PRG_LONG) ? 24'(PROG_LONG_P) :
                          24'(PROG_SHORT_P);
  wire [23:0] prg_half_w = prg_len_w >> 1;
  wire prg_last_w = (prg_cnt_r + 24'h000001) >= prg_len_w;
  wire prg_run_w = prg_r == MSC_PRG_RUN;
  wire two_phase_w = (prg_code_r == PRG_BOTH) | (prg_code_r == PRG_LONG);
  wire first_half_w = prg_cnt_r < prg_half_w;

  // Programming sequencer: idle, timed run, one done cycle.
  always_comb begin
    prg_nxt = prg_r;
    case (prg_r)
      MSC_PRG_IDLE: begin
        if (prog_start_in) begin
          prg_nxt = MSC_PRG_RUN;
        end
      end
      MSC_PRG_RUN: begin
        if (prg_last_w) begin
          prg_nxt = MSC_PRG_DONE;
        end
      end
      MSC_PRG_DONE: begin
        prg_nxt = MSC_PRG_IDLE;
      end
      default: begin
        prg_nxt = MSC_PRG_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      prg_r <= MSC_PRG_IDLE;
      prg_cnt_r <= 24'h000000;
      prg_code_r <= PRG_BOTH;
    end else begin
      prg_r <= prg_nxt;
      prg_cnt_r <= prg_run_w ? prg_cnt_r + 24'h000001 : 24'h000000;
      if (prg_r == MSC_PRG_IDLE && prog_start_in) begin
        prg_code_r <= cfg_r.prog_time;
      end
    end
  end

  // Two-phase codes erase in the first half and write in the second.
  assign prog_busy_out = prg_run_w;
  assign prog_done_out = prg_r == MSC_PRG_DONE;
  assign prog_erase_out = prg_run_w &
    ((prg_code_r == PRG_ERASE) | (two_phase_w & first_half_w));
  assign prog_write_out = prg_run_w &
    ((prg_code_r == PRG_WRITE) | (two_phase_w & ~first_half_w));

  // Checks on the steered behaviour.
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);

  sequence s_p4_edge;
    cfg_r.irq_pin_sel && cfg_r.irq_excl_en && !cfg_r.irq_edge_fall &&
      p4_rise;
  endsequence
  property p_irq_route; // RQ1
    s_p4_edge |=> cpu_irq_out ##1 meas_pause_out;
  endproperty
  a_irq_route: assert property (p_irq_route) // RQ1
    else $error("Pin 4 rising edge gave no interrupt.");

  property p_irq_edge; // RQ7
    cfg_r.irq_edge_fall && !src_fall_w |=> !cpu_irq_out;
  endproperty
  a_irq_edge: assert property (p_irq_edge) // RQ7
    else $error("Interrupt taken on the wrong edge.");

  property p_pause_hold; // RQ8
    meas_pause_out && !irq_service_done_in && !irq_fire_w |=>
      meas_pause_out;
  endproperty
  a_pause_hold: assert property (p_pause_hold) // RQ8
    else $error("Measurement resumed before servicing ended.");

  property p_lcd_pw1; // RQ11
    $rose(lcd_act_w) && cfg_r.lcd_clk_sel == LCD_PW1 && !cfg_load_in |->
      lcd_act_w ##1 lcd_act_w ##1 !lcd_act_w;
  endproperty
  a_lcd_pw1: assert property (p_lcd_pw1) // RQ11
    else $error("Display clock pulse width is not 100 ns.");

  property p_lcd_pol; // RQ2
    !lcd_act_w && !cfg_r.lcd_open_drain && !cfg_load_in |=>
      lcd_out_r == !cfg_r.lcd_pol;
  endproperty
  a_lcd_pol: assert property (p_lcd_pol) // RQ2
    else $error("Display clock idles at the wrong level.");

  property p_open_drain; // RQ16
    cfg_r.lcd_open_drain && !cfg_load_in |=> !lcd_clk_out;
  endproperty
  a_open_drain: assert property (p_open_drain) // RQ16
    else $error("Open-drain display clock drove high.");

  property p_comp; // RQ5
    cfg_r.comp_switch == CMP_MEAS |-> comp_on_out == meas_active_in;
  endproperty
  a_comp: assert property (p_comp) // RQ5
    else $error("Comparator not on during measurement only.");

  property p_p3_uart; // RQ9
    !cfg_r.pin3_is_input && cfg_r.pin3_function_select == P3_UART &&
      !cfg_load_in |=> multipurpose_pin_3_out == $past(uart_txd_in) &&
      multipurpose_pin_3_oe_out;
  endproperty
  a_p3_uart: assert property (p_p3_uart) // RQ9
    else $error("Pin 3 does not carry serial transmit.");

  property p_refr_avg; // RQ14
    refr_avg_w && !cfg_load_in |=> refresh_out == $past(avg_end_in);
  endproperty
  a_refr_avg: assert property (p_refr_avg) // RQ14
    else $error("Refresh does not follow the averaging end.");

  property p_prg_erase; // RQ18
    prg_run_w && prg_code_r == PRG_ERASE |-> prog_erase_out &&
      !prog_write_out;
  endproperty
  a_prg_erase: assert property (p_prg_erase) // RQ18
    else $error("Erase-only programming wrote.");
endmodule
`default_nettype wire

// file: src/msc_sync_edge.sv
// Two-stage synchroniser with edge detection for one pin input.
// Assumes the pin is asynchronous to core_clk_in.
`timescale 1ns/10ps
`default_nettype none
module msc_sync_edge (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic pin_in,
  output logic level_out,
  output logic rise_out,
  output logic fall_out
);
  logic meta_r;
  logic sync_r;
  logic prev_r;

  // Only the second stage and later are looked at by logic.
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign level_out = sync_r;
  assign rise_out = sync_r & ~prev_r;
  assign fall_out = ~sync_r & prev_r;
endmodule
`default_nettype wire

// file: src/msc_tick_div.sv
// Programmable period divider giving a one-cycle tick every period cycles.
// Assumes period_in is at least one and stable while running.
`timescale 1ns/10ps
`default_nettype none
module msc_tick_div #(
  parameter int unsigned W = 24
) (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic restart_in,
  input wire logic [W-1:0] period_in,
  output logic tick_out
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  wire last_w = (cnt_r + W'(1)) >= period_in;

  // Restart holds the count at zero so a new period starts cleanly.
  assign cnt_nxt = (restart_in || last_w) ? '0 : cnt_r + W'(1);
  assign tick_out = last_w & ~restart_in;

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule
`default_nettype wire
